// *** src/serial_dac_load_logic.sv ***
// Load control of a 12-bit multiplying converter with a three-wire serial input.
// Assumes serial clock, data and load strobe arrive as pins from a host on
// its own clock; the core clock runs at 40 MHz with no fixed phase to them.
`timescale 1ns/100ps
`default_nettype none

module serial_dac_load_logic #(
    parameter int WORD_W = dac_load_pkg::WORD_W
) (
    input  wire logic                       core_clk,
    input  wire logic                       nrst,
    input  wire logic                       sclk,
    input  wire logic                       serial_data_in,
    input  wire logic                       load_strobe_n,
    output var  dac_load_pkg::dac_view_type dac_view_q,
    output var  logic                       capture_pulse_q
);

    // ************************************************************
    // Serial clock domain
    // ************************************************************

    logic [WORD_W-1:0] shift_word_q;

    // The shift register lives on the host's clock and is static while the
    // strobe is low, which is what makes the word safe to copy across.
    serial_shift_link #(
        .WORD_W (WORD_W)
    ) u_link (
        .sclk           (sclk),
        .nrst           (nrst),
        .serial_data_in (serial_data_in),
        .load_strobe_n  (load_strobe_n),
        .shift_word_q   (shift_word_q)
    );

    // ************************************************************
    // Crossing into the core clock domain
    // ************************************************************

    logic              strobe_meta_q;
    logic              strobe_sync_q;
    logic              strobe_old_q;
    logic [WORD_W-1:0] word_meta_q;
    logic [WORD_W-1:0] word_sync_q;
    logic              strobe_meta_d;
    logic              strobe_sync_d;
    logic              strobe_old_d;
    logic [WORD_W-1:0] word_meta_d;
    logic [WORD_W-1:0] word_sync_d;

    // The strobe passes two flip-flops; a third stage gives its previous level.
    // The word is copied through two stages too; it is only used while the
    // strobe has been seen low on two cycles, when the host keeps it quiet.
    always_comb begin
        strobe_meta_d = load_strobe_n;
        strobe_sync_d = strobe_meta_q;
        strobe_old_d  = strobe_sync_q;
        word_meta_d   = shift_word_q;
        word_sync_d   = word_meta_q;
    end

    // Crossing registers; the strobe idles high so nothing loads after reset.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            strobe_meta_q <= 1'b1;
            strobe_sync_q <= 1'b1;
            strobe_old_q  <= 1'b1;
            word_meta_q   <= dac_load_pkg::CODE_RESET;
            word_sync_q   <= dac_load_pkg::CODE_RESET;
        end else begin
            strobe_meta_q <= strobe_meta_d;
            strobe_sync_q <= strobe_sync_d;
            strobe_old_q  <= strobe_old_d;
            word_meta_q   <= word_meta_d;
            word_sync_q   <= word_sync_d;
        end
    end

    // ************************************************************
    // Converter register and load control
    // ************************************************************

    // Tells whether a code is the all-ones full-scale code.
    function automatic logic is_full_scale(input logic [WORD_W-1:0] code);
        return code == dac_load_pkg::CODE_FULL;
    endfunction

    dac_load_pkg::load_state_type state_q;
    dac_load_pkg::load_state_type state_d;
    dac_load_pkg::dac_view_type   dac_view_d;
    logic                         capture_pulse_d;
    logic                         follow;

    // The strobe counts as low once both the synced and the older stage agree.
    assign follow = !strobe_sync_q && !strobe_old_q;

    // Transparent while the strobe is low; its rise keeps the last copy.
    always_comb begin
        state_d         = state_q;
        dac_view_d      = dac_view_q;
        capture_pulse_d = 1'b0;
        unique case (state_q)
            dac_load_pkg::LATCHED: begin
                if (follow) begin
                    state_d         = dac_load_pkg::FOLLOWING;
                    dac_view_d.code = word_sync_q;
                end
            end
            dac_load_pkg::FOLLOWING: begin
                if (strobe_sync_q) begin
                    state_d         = dac_load_pkg::LATCHED;
                    capture_pulse_d = 1'b1;
                end else begin
                    dac_view_d.code = word_sync_q;
                end
            end
        endcase
        dac_view_d.loading = (state_d == dac_load_pkg::FOLLOWING);
        // Bit 11 weighs half the reference; all ones sits one step below it,
        // and the current leaves the output with the polarity inverted.
        dac_view_d.full_scale = is_full_scale(dac_view_d.code);
    end

    // Load control registers; the code holds while the strobe is high.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q         <= dac_load_pkg::LATCHED;
            dac_view_q      <= '{code: dac_load_pkg::CODE_RESET, loading: 1'b0,
                                 full_scale: 1'b0};
            capture_pulse_q <= 1'b0;
        end else begin
            state_q         <= state_d;
            dac_view_q      <= dac_view_d;
            capture_pulse_q <= capture_pulse_d;
        end
    end

    // ************************************************************
    // Checks on the core clock
    // ************************************************************

    default clocking core_cb @(posedge core_clk);
    endclocking

    default disable iff (!nrst);

    // The strobe is seen low on two cycles, then the code copies the word.
    sequence strobe_seen_low;
        !strobe_sync_q && !strobe_old_q;
    endsequence

    // The strobe is seen rising while the code follows.
    sequence strobe_seen_rise;
        state_q == dac_load_pkg::FOLLOWING && strobe_sync_q;
    endsequence

    hold_when_high_a: assert property (
        strobe_sync_q && strobe_old_q |=> $stable(dac_view_q.code))
        else $error("converter code changed while the strobe was high");

    follow_when_low_a: assert property (
        strobe_seen_low |=> dac_view_q.code == $past(word_sync_q) && dac_view_q.loading)
        else $error("converter code did not follow the shift word");

    capture_once_a: assert property (
        strobe_seen_rise |=> capture_pulse_q && !dac_view_q.loading
                             ##1 !capture_pulse_q && $stable(dac_view_q.code))
        else $error("strobe rise did not hold the code with one pulse");

    change_cause_a: assert property (
        !$stable(dac_view_q.code) |-> $past(follow))
        else $error("converter code changed without the strobe low");

    full_scale_flag_a: assert property (
        dac_view_q.full_scale == (dac_view_q.code == dac_load_pkg::CODE_FULL))
        else $error("full-scale flag does not match the code");

    loading_state_a: assert property (
        dac_view_q.loading == (state_q == dac_load_pkg::FOLLOWING))
        else $error("loading flag disagrees with the load state");

endmodule
`default_nettype wire

// *** inc/dac_load_pkg.sv ***
// Shared constants and types of the serial converter load logic.
// Assumes a core clock of 40 MHz and a serial clock supplied by the host.

package dac_load_pkg;

    // ************************************************************
    // Word layout, reset and full-scale codes, and core clock period
    // ************************************************************

    // Length of the serial word and of the converter register.
    localparam int          WORD_W     = 12;
    // Converter code held after reset.
    localparam logic [11:0] CODE_RESET = 12'h000;
    // All-ones code, one step below the reference magnitude.
    localparam logic [11:0] CODE_FULL  = 12'hfff;
    // Core clock period in nanoseconds.
    localparam int          CORE_CLK_PERIOD_NS = 25;

    // ************************************************************
    // Types
    // ************************************************************

    // Converter register as seen by the analog switches.
    typedef struct packed {
        logic [11:0] code;
        logic        loading;
        logic        full_scale;
    } dac_view_type;

    // Load control states.
    typedef enum logic [0:0] {
        LATCHED,
        FOLLOWING
    } load_state_type;

endpackage

// *** src/serial_shift_link.sv ***
// Serial-in shift register running on the host's serial clock.
// Assumes the host changes data and strobe away from rising serial clock edges.
`timescale 1ns/100ps
`default_nettype none

module serial_shift_link #(
    parameter int WORD_W = dac_load_pkg::WORD_W
) (
    input  wire logic              sclk,
    input  wire logic              nrst,
    input  wire logic              serial_data_in,
    input  wire logic              load_strobe_n,
    output var  logic [WORD_W-1:0] shift_word_q
);

    // ************************************************************
    // Shift register
    // ************************************************************

    logic [WORD_W-1:0] shift_word_d;

    // While the strobe is high each rising edge shifts one bit in at the bottom.
    always_comb begin
        shift_word_d = shift_word_q;
        if (load_strobe_n) begin
            shift_word_d = {shift_word_q[WORD_W-2:0], serial_data_in};
        end
    end

    // Only the rising edge of the serial clock touches the register.
    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            shift_word_q <= dac_load_pkg::CODE_RESET;
        end else begin
            shift_word_q <= shift_word_d;
        end
    end

    // ************************************************************
    // Helper count for the bit order check
    // ************************************************************

    // Wide enough to count up to one whole word.
    localparam int RUN_W = $clog2(WORD_W + 1);

    logic [RUN_W-1:0] high_run_q;
    logic [RUN_W-1:0] high_run_d;

    // Counts rising edges in a row that saw the strobe high, stopping at a whole word.
    // The check below needs a long run of shifts, and a counter keeps it cheap.
    always_comb begin
        high_run_d = '0;
        if (load_strobe_n) begin
            high_run_d = high_run_q;
            if (high_run_q != RUN_W'(WORD_W)) begin
                high_run_d = high_run_q + RUN_W'(1);
            end
        end
    end

    // Registers the run count on the serial clock.
    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            high_run_q <= '0;
        end else begin
            high_run_q <= high_run_d;
        end
    end

    // ************************************************************
    // Checks on the serial clock
    // ************************************************************

    shift_in_a: assert property (@(posedge sclk) disable iff (!nrst)
        load_strobe_n |=> shift_word_q == {$past(shift_word_q[WORD_W-2:0]),
                                           $past(serial_data_in)})
        else $error("shift register did not advance by one bit");

    hold_low_a: assert property (@(posedge sclk) disable iff (!nrst)
        !load_strobe_n |=> $stable(shift_word_q))
        else $error("shift register moved while the strobe was low");

    msb_first_a: assert property (@(posedge sclk) disable iff (!nrst)
        load_strobe_n && high_run_q >= RUN_W'(WORD_W - 1)
            |=> shift_word_q[WORD_W-1] == $past(serial_data_in, WORD_W))
        else $error("first of the last twelve bits is not at the top");

endmodule
`default_nettype wire

// *** verif/serial_host.sv ***
// Host model driving the three serial pins of the converter load logic.
// Assumes the bench calls its tasks one at a time and never while reset is held.
`timescale 1ns/100ps
`default_nettype none

module serial_host (
    output var logic sclk,
    output var logic serial_data_in,
    output var logic load_strobe_n
);
    // ************************************************************
    // Pin state
    // ************************************************************

    // The serial clock stands low outside frames; the strobe idles high.
    initial begin
        sclk           = 1'b0;
        serial_data_in = 1'b0;
        load_strobe_n  = 1'b1;
    end

    // Shifts the low n bits of a value out, top bit first, 160 ns a bit.
    task automatic send_bits(input int n, input logic [31:0] value);
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_in <= value[i];
            #80;
            sclk <= 1'b1;
            #80;
            sclk <= 1'b0;
        end
        // A released data line shows the inverse so stale levels never pass.
        #40;
        serial_data_in <= ~serial_data_in;
    endtask

    // Drives the strobe; the clock stays low well past every rise.
    task automatic set_strobe(input logic level);
        load_strobe_n <= level;
        #200;
    endtask
endmodule
`default_nettype wire

// *** verif/serial_dac_load_logic_tb.sv ***
// Self-checking bench of the converter load logic with a serial host model.
// Assumes the design and package are compiled before this file.
`timescale 1ns/100ps
`default_nettype none

module serial_dac_load_logic_tb;
    // ************************************************************
    // Clock, reset and wiring
    // ************************************************************

    logic                       core_clk;
    logic                       nrst;
    wire logic                  sclk;
    wire logic                  serial_data_in;
    wire logic                  load_strobe_n;
    dac_load_pkg::dac_view_type dac_view_q;
    logic                       capture_pulse_q;
    int                         failures;
    int                         cmp_count;

    // Core clock at 40 MHz.
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    serial_host host_u (
        .sclk           (sclk),
        .serial_data_in (serial_data_in),
        .load_strobe_n  (load_strobe_n)
    );

    serial_dac_load_logic dut_u (
        .core_clk        (core_clk),
        .nrst            (nrst),
        .sclk            (sclk),
        .serial_data_in  (serial_data_in),
        .load_strobe_n   (load_strobe_n),
        .dac_view_q      (dac_view_q),
        .capture_pulse_q (capture_pulse_q)
    );

    // ************************************************************
    // Checking and closing
    // ************************************************************

    // Compares one value and counts the result.
    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************

    // Pulses the strobe and checks the follow, the hold and the capture pulse.
    task automatic load_and_check(input logic [11:0] word);
        logic seen;
        seen = 1'b0;
        host_u.set_strobe(1'b0);
        repeat (4) @(posedge core_clk);
        #1;
        chk("code while low", word, dac_view_q.code);
        chk("loading", 12'h001, {11'h000, dac_view_q.loading});
        // The pulse comes while the host still waits after the rise, so watch meanwhile.
        fork
            host_u.set_strobe(1'b1);
            for (int i = 0; i < 10; i++) begin
                @(posedge core_clk);
                #1;
                if (capture_pulse_q === 1'b1) begin
                    seen = 1'b1;
                end
            end
        join
        chk("capture pulse", 12'h001, {11'h000, seen});
        chk("code held", word, dac_view_q.code);
        chk("loading off", 12'h000, {11'h000, dac_view_q.loading});
        chk("full scale", {11'h000, word == dac_load_pkg::CODE_FULL},
            {11'h000, dac_view_q.full_scale});
    endtask

    // Clocking with the strobe low must neither shift nor move the code.
    task automatic low_clock_ignored(input logic [11:0] word);
        host_u.set_strobe(1'b0);
        host_u.send_bits(4, 32'h0000_0005);
        repeat (4) @(posedge core_clk);
        #1;
        chk("code with strobe low", word, dac_view_q.code);
        host_u.set_strobe(1'b1);
        repeat (4) @(posedge core_clk);
        #1;
        chk("code after raise", word, dac_view_q.code);
    endtask

    // Shifting with the strobe high must leave the held code alone.
    task automatic shift_holds(input logic [11:0] held, input logic [11:0] next);
        host_u.send_bits(12, {20'h0_0000, next});
        repeat (4) @(posedge core_clk);
        #1;
        chk("code during shift", held, dac_view_q.code);
    endtask

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************

    initial begin
        failures  = 0;
        cmp_count = 0;
        nrst      = 1'b0;
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        chk("code after reset", dac_load_pkg::CODE_RESET, dac_view_q.code);
        chk("pulse after reset", 12'h000, {11'h000, capture_pulse_q});
        repeat (2) @(posedge core_clk);
        host_u.send_bits(12, 32'h0000_0a5c);
        load_and_check(12'ha5c);
        low_clock_ignored(12'ha5c);
        shift_holds(12'ha5c, 12'h3c1);
        load_and_check(12'h3c1);
        host_u.send_bits(16, 32'h0000_7fff);
        load_and_check(12'hfff);
        host_u.send_bits(20, 32'h000f_f001);
        load_and_check(12'h001);
        load_and_check(12'h001);
        stop_test();
    end

    // Cuts a hang short well after the sequence should have ended.
    initial begin
        #200000;
        failures++;
        stop_test();
    end
endmodule
`default_nettype wire
